// [logic/cmic_consts.svh]
// Constants for the mode and interrupt control block
`ifndef CMIC_CONSTS_SVH
`define CMIC_CONSTS_SVH
`define CMIC_STACK_EMU_HI   8'h01
`define CMIC_INDEX_EMU_HI   8'h00
`define CMIC_BANK_CLEAR     8'h00
`define CMIC_TRAP_USER_MAX  8'h7f
`define CMIC_SP_RST         16'h01ff
`define CMIC_STAT_RST       8'h34
`define CMIC_STAT_C_BIT     0
`define CMIC_STAT_I_BIT     2
`define CMIC_STAT_D_BIT     3
`define CMIC_STAT_X_BIT     4
`define CMIC_STAT_M_BIT     5
`endif

// [logic/cmic_pkg.sv]
// Types for the mode and interrupt control block
package cmic_pkg;
    typedef enum logic [2:0] {
        CMIC_OP_NONE  = 3'b000,
        CMIC_OP_CLRST = 3'b001,
        CMIC_OP_SETST = 3'b010,
        CMIC_OP_PULST = 3'b011,
        CMIC_OP_XFER  = 3'b100,
        CMIC_OP_MOVE  = 3'b101,
        CMIC_OP_SLEEP = 3'b110,
        CMIC_OP_STOP  = 3'b111
    } cmic_op_t;
    typedef enum logic [2:0] {
        CMIC_XD_NONE = 3'b000,
        CMIC_XD_ACC  = 3'b001,
        CMIC_XD_SP   = 3'b010,
        CMIC_XD_DIR  = 3'b011,
        CMIC_XD_IDX  = 3'b100
    } cmic_xdst_t;
    typedef enum logic [1:0] {
        CMIC_RUN   = 2'b00,
        CMIC_SLEEP = 2'b01,
        CMIC_HALT  = 2'b10
    } cmic_state_t;
    typedef struct packed {
        cmic_op_t   op;
        logic [7:0] arg;
        cmic_xdst_t xdst;
        logic       wide16;
        logic [31:0] xval;
    } cmic_cmd_t;
    typedef struct packed {
        logic [1:0] mode_jump;
        logic       trap;
        logic       break_op;
    } cmic_swint_t;
endpackage

// [logic/cmic_core_ctrl.sv]
// Mode, bank and interrupt control of the processor core
// What this block does
// RL1 - Ready low holds data bus in transfer state, as if clock high.
// RL2 - Outside latch takes bank address, closed while clock or ready low.
// RL3 - Width-select output shows the AND of accumulator and index width flags.
// RL4 - Width-select may be invalid in fetch cycle after status-changing ops.
// RL5 - Emulation: status set/clear ops leave width flags at one.
// RL6 - Indirect jumps use direct bank; indexed-indirect ones use program bank.
// RL7 - Entering emulation sets width flags, stack high 01, index highs 00.
// RL8 - Mode change keeps low bytes of stack, indexes and accumulator.
// RL9 - Native interrupts push old program bank then clear it.
// RL10 - Emulation interrupts clear program and data banks, no push.
// RL11 - Any taken interrupt clears decimal flag, except in a cycle where mode_switch enters emulation or selects native mode, which takes priority and drops it.
// RL12 - Sleep pulls ready low; reset, NMI or IRQ wake into handler.
// RL13 - Masked IRQ wakes sleep and continues after sleep op.
// RL14 - Abort during sleep stops it and sets sleep_aborted_r; nothing returns to sleep op.
// RL15 - Stop op gates clock high; bus held, no bank multiplexed.
// RL16 - Only reset restarts after stop; clock back on reset fall.
// RL17 - Trap signatures 00-7F user, 80-FF reserved.
// RL18 - Ready low during write stalls native, ignored in emulation.
// RL19 - Block moves load data bank with destination bank byte.
// RL20 - Priority: reset, abort, NMI, IRQ.
// RL21 - Transfers carry at most 16 bits; destination width decides; stack/direct 16.
// RL22 - Legacy emulation stack transfer forces 01; stack to acc 16 bits.
// RL23 - Abort input low at most one cycle per event.
`timescale 1ns/10ps
`include "cmic_consts.svh"
module cmic_core_ctrl
    import cmic_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        ready_pin,
    input  wire logic        abort_n_pin,
    input  wire logic        nmi_n_pin,
    input  wire logic        irq_n_pin,
    input  wire logic        cpu_write,
    input  wire logic        cmd_valid,
    input  wire cmic_cmd_t   cmd,
    input  wire logic [7:0]  pulled_status,
    input  wire logic        mode_switch,
    input  wire logic        mode_emul_req,
    input  wire logic        legacy_emul,
    input  wire cmic_swint_t swint,
    output logic             ready_drive_low,
    output logic             phase_two_clock_en,
    output logic             bus_transfer_hold,
    output logic             bank_mux_en,
    output logic             width_select,
    output logic             width_valid,
    output logic             cpu_stall,
    output logic             emul_mode,
    output logic [7:0]       status_r,
    output logic [7:0]       program_bank_register,
    output logic [7:0]       data_bank_register,
    output logic [7:0]       pushed_bank,
    output logic             push_bank_stb,
    output logic [15:0]      stack_ptr,
    output logic [15:0]      index_x,
    output logic [15:0]      index_y,
    output logic [31:0]      acc_r,
    output logic [15:0]      direct_r,
    output logic [2:0]       vector_sel,
    output logic             vector_stb,
    output logic             resume_next,
    output logic             trap_reserved,
    output logic             indirect_bank_sel
);
    ////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for pins
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_s1_r <= 4'hf;
            pin_s2_r <= 4'hf;
        end else begin
            pin_s1_r <= {ready_pin, abort_n_pin, nmi_n_pin, irq_n_pin};
            pin_s2_r <= pin_s1_r;
        end
    end
    wire ready_s = pin_s2_r[3];
    wire abort_s = !pin_s2_r[2];
    wire irq_s   = !pin_s2_r[0];
    logic nmi_prev_r;
    // Falling edge only: a held request must not retrigger every cycle
    wire nmi_edge = !pin_s2_r[1] && nmi_prev_r;

    ////////////////////////////////////////////////////////////////////
    // State and registers
    cmic_state_t state_r;
    cmic_state_t state_nxt;
    logic        emul_r;
    logic        sleep_aborted_r;
    logic        fetch_after_st_r;

    wire is_run   = (state_r == CMIC_RUN);
    wire is_sleep = (state_r == CMIC_SLEEP);
    wire is_halt  = (state_r == CMIC_HALT);
    wire irq_mask = status_r[`CMIC_STAT_I_BIT];
    wire hw_ev    = abort_s || nmi_edge || (irq_s && !irq_mask);
    wire sw_ev    = is_run && cmd_valid && (swint.break_op || swint.trap);
    wire take_int = (hw_ev && !is_halt) || sw_ev;         // RL11
    wire [2:0] pri_vec = abort_s  ? 3'h1 :                // RL20
                         nmi_edge ? 3'h2 :
                         (irq_s && !irq_mask) ? 3'h3 :
                         swint.break_op ? 3'h4 : 3'h5;
    wire masked_wake = is_sleep && irq_s && irq_mask;     // RL13
    wire cmd_go  = is_run && cmd_valid && !cpu_stall;
    wire to_emul = mode_switch && mode_emul_req && !emul_r;

    function automatic logic [7:0] width_flags(input logic [7:0] s, input logic emu);
        width_flags = s;
        if (emu) begin
            width_flags[`CMIC_STAT_M_BIT] = 1'b1;
            width_flags[`CMIC_STAT_X_BIT] = 1'b1;
        end
    endfunction

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            CMIC_RUN: begin
                if (cmd_go && cmd.op == CMIC_OP_SLEEP) begin
                    state_nxt = CMIC_SLEEP;                 // RL12
                end else if (cmd_go && cmd.op == CMIC_OP_STOP) begin
                    state_nxt = CMIC_HALT;                  // RL15
                end
            end
            CMIC_SLEEP: begin
                if (take_int || masked_wake) begin
                    state_nxt = CMIC_RUN;                   // RL12
                end
            end
            CMIC_HALT: state_nxt = CMIC_HALT;               // RL16
            default:   state_nxt = CMIC_RUN;
        endcase
    end

    // Halt only ends through reset; the reset clears state at its assertion
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= CMIC_RUN;                            // RL16
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            emul_r                <= 1'b1;
            status_r              <= `CMIC_STAT_RST;
            program_bank_register <= `CMIC_BANK_CLEAR;
            data_bank_register    <= `CMIC_BANK_CLEAR;
            stack_ptr             <= `CMIC_SP_RST;
            index_x               <= 16'h0000;
            index_y               <= 16'h0000;
            acc_r                 <= 32'h0000_0000;
            direct_r              <= 16'h0000;
            pushed_bank           <= 8'h00;
            push_bank_stb         <= 1'b0;
            vector_sel            <= 3'h0;
            vector_stb            <= 1'b0;
            resume_next           <= 1'b0;
            sleep_aborted_r       <= 1'b0;
            fetch_after_st_r      <= 1'b0;
            nmi_prev_r            <= 1'b1;
            trap_reserved         <= 1'b0;
        end else begin
            nmi_prev_r       <= pin_s2_r[1];
            push_bank_stb    <= 1'b0;
            vector_stb       <= 1'b0;
            resume_next      <= masked_wake && !take_int;                      // RL13
            fetch_after_st_r <= cmd_go && (cmd.op == CMIC_OP_CLRST || cmd.op == CMIC_OP_SETST ||
                                           cmd.op == CMIC_OP_PULST);          // RL4
            if (is_sleep && abort_s) begin
                sleep_aborted_r <= 1'b1;                                       // RL14
            end else if (take_int && !abort_s) begin
                sleep_aborted_r <= 1'b0;
            end
            if (sw_ev && swint.trap) begin
                trap_reserved <= (cmd.arg > `CMIC_TRAP_USER_MAX);              // RL17
            end
            if (to_emul) begin
                emul_r        <= 1'b1;
                status_r      <= width_flags(status_r, 1'b1);                  // RL7
                stack_ptr     <= {`CMIC_STACK_EMU_HI, stack_ptr[7:0]};         // RL8
                index_x       <= {`CMIC_INDEX_EMU_HI, index_x[7:0]};
                index_y       <= {`CMIC_INDEX_EMU_HI, index_y[7:0]};
            end else if (mode_switch && !mode_emul_req) begin
                emul_r <= 1'b0;
            end else if (take_int) begin
                status_r[`CMIC_STAT_D_BIT] <= 1'b0;                            // RL11
                status_r[`CMIC_STAT_I_BIT] <= 1'b1;
                program_bank_register      <= `CMIC_BANK_CLEAR;                // RL9
                vector_sel                 <= pri_vec;
                vector_stb                 <= 1'b1;
                if (emul_r) begin
                    data_bank_register <= `CMIC_BANK_CLEAR;                    // RL10
                end else begin
                    pushed_bank   <= program_bank_register;                    // RL9
                    push_bank_stb <= 1'b1;
                end
            end else if (cmd_go) begin
                unique case (cmd.op)
                    CMIC_OP_CLRST: status_r <= width_flags(status_r & ~cmd.arg, emul_r); // RL5
                    CMIC_OP_SETST: status_r <= width_flags(status_r | cmd.arg, emul_r);  // RL5
                    CMIC_OP_PULST: status_r <= width_flags(pulled_status, emul_r);
                    CMIC_OP_MOVE:  data_bank_register <= cmd.arg;              // RL19
                    CMIC_OP_XFER: begin
                        unique case (cmd.xdst)
                            CMIC_XD_SP: begin
                                if (emul_r && legacy_emul) begin
                                    stack_ptr <= {`CMIC_STACK_EMU_HI, cmd.xval[7:0]}; // RL22
                                end else begin
                                    stack_ptr <= cmd.xval[15:0];               // RL21
                                end
                            end
                            CMIC_XD_DIR: direct_r <= cmd.xval[15:0];           // RL21
                            CMIC_XD_ACC: begin
                                if (cmd.wide16 || !status_r[`CMIC_STAT_M_BIT]) begin
                                    acc_r[15:0] <= cmd.xval[15:0];             // RL22
                                end else begin
                                    acc_r[7:0] <= cmd.xval[7:0];               // RL21
                                end
                            end
                            CMIC_XD_IDX: begin
                                if (status_r[`CMIC_STAT_X_BIT]) begin
                                    index_x[7:0] <= cmd.xval[7:0];             // RL21
                                end else begin
                                    index_x <= cmd.xval[15:0];
                                end
                            end
                            default: ;
                        endcase
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin-side outputs
    // Write stall is ignored in emulation so legacy timing is kept
    assign cpu_stall          = !ready_s && !(cpu_write && emul_r);        // RL18
    assign ready_drive_low    = is_sleep;                                   // RL12
    assign phase_two_clock_en = !is_halt;                                   // RL15
    assign bus_transfer_hold  = is_halt || !ready_s || is_sleep;            // RL1
    assign bank_mux_en        = !bus_transfer_hold;                         // RL15
    assign width_select       = status_r[`CMIC_STAT_M_BIT] & status_r[`CMIC_STAT_X_BIT]; // RL3
    assign width_valid        = !fetch_after_st_r;                          // RL4
    assign emul_mode          = emul_r;
    assign indirect_bank_sel  = swint.mode_jump[1];                         // RL6

    ////////////////////////////////////////////////////////////////////
    // Checks
    AST_EMU_WIDTH: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL5
        emul_r |-> (status_r[`CMIC_STAT_M_BIT] && status_r[`CMIC_STAT_X_BIT]))
        else $error("Width flags low in emulation");
    AST_EMU_ENTRY: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL7
        to_emul |=> (stack_ptr[15:8] == 8'h01 && index_x[15:8] == 8'h00 && index_y[15:8] == 8'h00))
        else $error("Emulation entry high bytes wrong");
    AST_LOW_KEPT: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL8
        to_emul |=> (stack_ptr[7:0] == $past(stack_ptr[7:0]) && acc_r == $past(acc_r)))
        else $error("Mode change altered low bytes");
    AST_DEC_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL11
        (take_int && !mode_switch) |=> !status_r[`CMIC_STAT_D_BIT] && vector_stb)
        else $error("Decimal flag not cleared on interrupt");
    AST_NAT_PUSH: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL9
        (take_int && !mode_switch && !emul_r) |=>
            push_bank_stb && pushed_bank == $past(program_bank_register) && program_bank_register == 8'h00)
        else $error("Native bank push wrong");
    AST_EMU_BANKS: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL10
        (take_int && !mode_switch && emul_r) |=>
            !push_bank_stb && program_bank_register == 8'h00 && data_bank_register == 8'h00)
        else $error("Emulation bank clear wrong");
    AST_HALT_STAYS: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL16
        is_halt |=> is_halt && !phase_two_clock_en)
        else $error("Halt left without reset");
    AST_SLEEP_READY: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL12
        (cmd_go && cmd.op == CMIC_OP_SLEEP) |=> ready_drive_low && bus_transfer_hold)
        else $error("Sleep did not pull ready low");
    AST_WRITE_STALL: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL18
        (!ready_s && cpu_write) |-> (cpu_stall == !emul_r))
        else $error("Write stall mode mismatch");
    AST_MOVE_BANK: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL19
        (cmd_go && cmd.op == CMIC_OP_MOVE && !take_int && !mode_switch) |=>
            data_bank_register == $past(cmd.arg))
        else $error("Block move bank not loaded");
endmodule

// [verif/cmic_ext_src.sv]
// Model of the external bus side and interrupt sources
`timescale 1ns/10ps
module cmic_ext_src (
    input  wire logic       sys_clk,
    input  wire logic       hold_ready,
    input  wire logic       irq_req,
    input  wire logic       nmi_req,
    input  wire logic       abort_req,
    input  wire logic       phase_two_clock_en,
    input  wire logic       bank_mux_en,
    input  wire logic [7:0] bank_in,
    output logic            ready_pin,
    output logic            irq_n_pin,
    output logic            nmi_n_pin,
    output logic            abort_n_pin,
    output logic [7:0]      bank_latched
);
    logic abort_q = 1'b0;
    initial begin
        ready_pin    = 1'b1;
        irq_n_pin    = 1'b1;
        nmi_n_pin    = 1'b1;
        abort_n_pin  = 1'b1;
        bank_latched = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        ready_pin   <= !hold_ready;
        irq_n_pin   <= !irq_req;
        nmi_n_pin   <= !nmi_req;
        // Only the rising request makes a low pulse, so a held request never repeats it
        abort_n_pin <= !(abort_req && !abort_q);
        abort_q     <= abort_req;
    end
    // Transparent latch, closed while the clock or ready is low
    always @* begin
        if (phase_two_clock_en && ready_pin && bank_mux_en) begin
            bank_latched = bank_in;
        end
    end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the mode and interrupt control block
`timescale 1ns/10ps
`include "cmic_consts.svh"
module tb_top
    import cmic_pkg::*;
;
    logic        sys_clk = 1'b0, rst_n = 1'b0, cpu_write = 1'b0, cmd_valid = 1'b0, mode_switch = 1'b0;
    logic        hold_ready = 1'b0, irq_req = 1'b0, nmi_req = 1'b0, abort_req = 1'b0;
    logic        mode_emul_req = 1'b1, legacy_emul = 1'b0, saw_vec, saw_res;
    logic        ready_pin, abort_n_pin, nmi_n_pin, irq_n_pin, ready_drive_low, phase_two_clock_en;
    logic        bus_transfer_hold, bank_mux_en, width_select, cpu_stall, emul_mode, push_bank_stb;
    logic        vector_stb, resume_next, trap_reserved, width_valid, indirect_bank_sel;
    logic [7:0]  pulled_status = 8'h00;
    cmic_cmd_t   cmd = '0;
    cmic_swint_t swint = '0;
    logic [7:0]  status_r, program_bank_register, data_bank_register, pushed_bank, bank_latched;
    logic [15:0] stack_ptr, index_x, index_y, direct_r;
    logic [31:0] acc_r, rv, sv;
    logic [2:0]  vector_sel, got_sel;
    logic [7:0]  trap_args [4];
    int          fail_count = 0, tests_run = 0, cyc = 0, seed = 69;

    always #4 sys_clk = ~sys_clk;

    cmic_core_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .ready_pin(ready_pin), .abort_n_pin(abort_n_pin),
        .nmi_n_pin(nmi_n_pin), .irq_n_pin(irq_n_pin), .cpu_write(cpu_write), .cmd_valid(cmd_valid), .cmd(cmd),
        .pulled_status(pulled_status), .mode_switch(mode_switch), .mode_emul_req(mode_emul_req),
        .legacy_emul(legacy_emul), .swint(swint), .ready_drive_low(ready_drive_low),
        .phase_two_clock_en(phase_two_clock_en), .bus_transfer_hold(bus_transfer_hold),
        .bank_mux_en(bank_mux_en), .width_select(width_select), .width_valid(width_valid),
        .cpu_stall(cpu_stall),
        .emul_mode(emul_mode), .status_r(status_r), .program_bank_register(program_bank_register),
        .data_bank_register(data_bank_register), .pushed_bank(pushed_bank), .push_bank_stb(push_bank_stb),
        .stack_ptr(stack_ptr), .index_x(index_x), .index_y(index_y), .acc_r(acc_r), .direct_r(direct_r),
        .vector_sel(vector_sel), .vector_stb(vector_stb), .resume_next(resume_next),
        .trap_reserved(trap_reserved), .indirect_bank_sel(indirect_bank_sel));

    cmic_ext_src ext_u (.sys_clk(sys_clk), .hold_ready(hold_ready), .irq_req(irq_req), .nmi_req(nmi_req),
        .abort_req(abort_req), .phase_two_clock_en(phase_two_clock_en), .bank_mux_en(bank_mux_en),
        .bank_in(program_bank_register), .ready_pin(ready_pin), .irq_n_pin(irq_n_pin),
        .nmi_n_pin(nmi_n_pin), .abort_n_pin(abort_n_pin), .bank_latched(bank_latched));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
    endtask
    task automatic issue(input cmic_op_t op, input logic [7:0] arg, input cmic_xdst_t xd,
                         input logic [31:0] xv, input logic b, input logic t);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd       <= cmic_cmd_t'{op: op, arg: arg, xdst: xd, wide16: 1'b0, xval: xv};
        swint     <= cmic_swint_t'{mode_jump: 2'b00, trap: t, break_op: b};
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        swint     <= '0;
        #1;
    endtask
    task automatic switch_mode(input logic e);
        @(posedge sys_clk);
        mode_switch   <= 1'b1;
        mode_emul_req <= e;
        @(posedge sys_clk);
        mode_switch   <= 1'b0;
        #1;
    endtask
    // Pins go through the model and two sync flops, so the wait is bounded at 12 cycles
    task automatic raise(input logic a, input logic n, input logic i);
        @(posedge sys_clk);
        abort_req <= a;
        nmi_req   <= n;
        irq_req   <= i;
        saw_vec = 1'b0;
        saw_res = 1'b0;
        for (int k = 0; k < 12 && !saw_vec && !saw_res; k++) begin
            @(posedge sys_clk);
            #1;
            saw_vec = (vector_stb === 1'b1);
            saw_res = (resume_next === 1'b1);
            got_sel = vector_sel;
        end
        @(posedge sys_clk);
        abort_req <= 1'b0;
        nmi_req   <= 1'b0;
        irq_req   <= 1'b0;
        repeat (12) @(posedge sys_clk);
        #1;
    endtask
    task automatic stall_chk(input logic exp);
        @(posedge sys_clk);
        hold_ready <= 1'b1;
        cpu_write  <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        check(bus_transfer_hold, 1);
        check(cpu_stall, exp);
        @(posedge sys_clk);
        hold_ready <= 1'b0;
        cpu_write  <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        check(cpu_stall, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        do_reset();
        check(status_r, `CMIC_STAT_RST);
        check(width_select, 1);
        issue(CMIC_OP_CLRST, 8'h30, CMIC_XD_NONE, 0, 0, 0);
        check(status_r[5:4], 2'b11);
        check(width_valid, 0);
        rv = $random(seed);
        pulled_status <= rv[7:0] | 8'h04;
        issue(CMIC_OP_PULST, 8'h00, CMIC_XD_NONE, 0, 0, 0);
        check(status_r, rv[7:0] | 8'h34);
        issue(CMIC_OP_SLEEP, 8'h00, CMIC_XD_NONE, 0, 0, 0);
        check(ready_drive_low, 1);
        raise(0, 0, 1);
        check({saw_res, saw_vec}, 2'b10);
        check(ready_drive_low, 0);
        rv = $random(seed);
        legacy_emul <= 1'b1;
        issue(CMIC_OP_XFER, 8'h00, CMIC_XD_SP, rv, 0, 0);
        check(stack_ptr, {8'h01, rv[7:0]});
        legacy_emul <= 1'b0;
        issue(CMIC_OP_MOVE, rv[15:8], CMIC_XD_NONE, 0, 0, 0);
        check(data_bank_register, rv[15:8]);
        issue(CMIC_OP_NONE, 8'h00, CMIC_XD_NONE, 0, 1, 0);
        check({program_bank_register, data_bank_register}, 16'h0000);
        check(push_bank_stb, 0);
        stall_chk(0);
        switch_mode(0);
        check(emul_mode, 0);
        issue(CMIC_OP_CLRST, 8'h30, CMIC_XD_NONE, 0, 0, 0);
        check(width_select, 0);
        stall_chk(1);
        rv = $random(seed);
        issue(CMIC_OP_XFER, 8'h00, CMIC_XD_DIR, rv, 0, 0);
        check(direct_r, rv[15:0]);
        sv = $random(seed);
        issue(CMIC_OP_XFER, 8'h00, CMIC_XD_SP, sv, 0, 0);
        check(stack_ptr, sv[15:0]);
        issue(CMIC_OP_MOVE, rv[31:24], CMIC_XD_NONE, 0, 0, 0);
        issue(CMIC_OP_SETST, 8'h08, CMIC_XD_NONE, 0, 0, 0);
        issue(CMIC_OP_NONE, 8'h00, CMIC_XD_NONE, 0, 1, 0);
        check(status_r[3], 0);
        check({push_bank_stb, pushed_bank, program_bank_register}, 17'h10000);
        check(data_bank_register, rv[31:24]);
        check(vector_sel, 3'h4);
        trap_args = '{8'h7f, 8'h80, 8'hff, rv[7:0]};
        foreach (trap_args[k]) begin
            issue(CMIC_OP_NONE, trap_args[k], CMIC_XD_NONE, 0, 0, 1);
            check(trap_reserved, trap_args[k] > 8'h7f);
        end
        raise(1, 1, 1);
        check(got_sel, 3'h1);
        raise(0, 1, 1);
        check(got_sel, 3'h2);
        issue(CMIC_OP_CLRST, 8'h04, CMIC_XD_NONE, 0, 0, 0);
        issue(CMIC_OP_SLEEP, 8'h00, CMIC_XD_NONE, 0, 0, 0);
        raise(0, 0, 1);
        check({saw_vec, got_sel}, 4'hb);
        issue(CMIC_OP_XFER, 8'h00, CMIC_XD_ACC, rv, 0, 0);
        issue(CMIC_OP_XFER, 8'h00, CMIC_XD_IDX, sv, 0, 0);
        switch_mode(1);
        check(stack_ptr, {8'h01, sv[7:0]});
        check({status_r[5:4], index_x[15:8]}, 10'h300);
        check({index_x, index_y}, {8'h00, sv[7:0], 16'h0000});
        check(acc_r, {16'h0000, rv[15:0]});
        issue(CMIC_OP_STOP, 8'h00, CMIC_XD_NONE, 0, 0, 0);
        check({phase_two_clock_en, bus_transfer_hold, bank_mux_en}, 3'b010);
        raise(0, 0, 1);
        check({saw_vec, phase_two_clock_en}, 2'b00);
        do_reset();
        check(phase_two_clock_en, 1);
        swint <= cmic_swint_t'{mode_jump: 2'b10, trap: 1'b0, break_op: 1'b0};
        #1;
        check(indirect_bank_sel, 1);
        summarize();
    end
endmodule
